// [hw/chipper_feed_control.sv]
`timescale 1ns/10ps
`include "chipper_feed_regs.svh"
module chipper_feed_control #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int HOLD_TICKS = `HOLD_TICKS
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Engine speed in RPM.
	input wire logic [15:0] engine_speed,
	// Keypad, high while pressed.
	input wire logic key_enter,
	input wire logic key_up,
	input wire logic key_down,
	input wire logic key_back,
	input wire logic key_menu,
	// Feed hydraulics and display.
	output logic feed_forward,
	output logic feed_reverse,
	output logic [1:0] feed_display,
	output logic override_active,
	output logic irq,
	// AXI4-Lite slave.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==================================================================
	// Declarations
	logic tick;
	logic [2:0] ctrl_reg;
	feed_pkg::speed_t feed_on_reg;
	feed_pkg::speed_t rev_trig_reg;
	logic [15:0] pulse_reg;
	logic [15:0] pulse_cnt_reg;
	logic [3:0] irq_status_reg;
	logic [3:0] irq_mask_reg;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;
	logic at_main_reg;
	logic menu_prev_reg;
	logic up_first_reg;
	logic down_first_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write;
	logic [31:0] wmask;
	logic [31:0] read_data;
	logic read_hit;
	logic write_hit;
	logic manual;
	logic engine_running;
	logic hold_fwd;
	logic auto_run;
	logic fwd_next;
	logic rev_next;
	logic pulse_expired;
	feed_pkg::auto_state_e auto_state;
	feed_pkg::override_state_e ov_state;
	feed_pkg::show_e show_next;
	hold_if h_enter();
	hold_if h_up();
	hold_if h_down();
	hold_if h_back();

	assign manual = ctrl_reg[`CTRL_MANUAL_BIT];
	assign engine_running = ctrl_reg[`CTRL_ENGINE_BIT];
	assign hold_fwd = ctrl_reg[`CTRL_VARIANT_BIT];
	assign auto_run = manual && engine_running && ov_state == feed_pkg::OV_NONE;

	// ==================================================================
	// Time base and key hold timers
	tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
		.clock(clock),
		.reset(reset),
		.tick(tick)
	);

	// Chords must start with the arrow key; enter pressed first does not arm.
	always_ff @(posedge clock) begin
		if (reset) begin
			up_first_reg <= 1'b0;
			down_first_reg <= 1'b0;
		end else begin
			up_first_reg <= key_up && (up_first_reg || !key_enter);
			down_first_reg <= key_down && (down_first_reg || !key_enter);
		end
	end

	assign h_enter.active = manual && key_enter && !key_up && !key_down
		&& !key_back && (at_main_reg || ov_state != feed_pkg::OV_NONE);
	assign h_up.active = ov_state != feed_pkg::OV_NONE && up_first_reg
		&& key_enter && !key_down && !key_back;
	assign h_down.active = ov_state != feed_pkg::OV_NONE && down_first_reg
		&& key_enter && !key_up && !key_back;
	assign h_back.active = ov_state != feed_pkg::OV_NONE && key_back;

	key_hold_timer #(.HOLD(HOLD_TICKS)) u_hold_enter (
		.clock(clock), .reset(reset), .tick(tick), .hold(h_enter));
	key_hold_timer #(.HOLD(HOLD_TICKS)) u_hold_up (
		.clock(clock), .reset(reset), .tick(tick), .hold(h_up));
	key_hold_timer #(.HOLD(HOLD_TICKS)) u_hold_down (
		.clock(clock), .reset(reset), .tick(tick), .hold(h_down));
	key_hold_timer #(.HOLD(HOLD_TICKS)) u_hold_back (
		.clock(clock), .reset(reset), .tick(tick), .hold(h_back));

	// ==================================================================
	// Automatic feed
	assign pulse_expired = tick && pulse_cnt_reg + 16'h0001 >= pulse_reg;

	always_ff @(posedge clock) begin
		if (reset || !auto_run) begin
			auto_state <= feed_pkg::AUTO_OFF;
			pulse_cnt_reg <= 16'h0000;
		end else begin
			unique case (auto_state)
			feed_pkg::AUTO_OFF: begin
				if (engine_speed >= feed_on_reg) begin
					auto_state <= feed_pkg::AUTO_FWD;
				end
			end
			feed_pkg::AUTO_FWD: begin
				if (engine_speed <= rev_trig_reg) begin
					auto_state <= feed_pkg::AUTO_REV;
					pulse_cnt_reg <= 16'h0000;
				end
			end
			feed_pkg::AUTO_REV: begin
				if (pulse_expired) begin
					auto_state <= feed_pkg::AUTO_OFF;
				end else if (tick) begin
					pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
				end
			end
			endcase
		end
	end

	// ==================================================================
	// Manual override and menu position
	always_ff @(posedge clock) begin
		if (reset || !manual) begin
			ov_state <= feed_pkg::OV_NONE;
		end else begin
			unique case (ov_state)
			feed_pkg::OV_NONE: begin
				if (h_enter.done && engine_speed < rev_trig_reg) begin
					ov_state <= feed_pkg::OV_IDLE;
				end
			end
			feed_pkg::OV_IDLE, feed_pkg::OV_FWD, feed_pkg::OV_REV: begin
				if (h_back.done) begin
					ov_state <= feed_pkg::OV_NONE;
				end else if (h_enter.done) begin
					ov_state <= feed_pkg::OV_IDLE;
				end else if (h_up.done) begin
					ov_state <= feed_pkg::OV_FWD;
				end else if (h_down.done) begin
					ov_state <= feed_pkg::OV_REV;
				end
			end
			endcase
		end
	end

	// The menu key only leaves the main menu while override is closed.
	always_ff @(posedge clock) begin
		if (reset) begin
			at_main_reg <= 1'b0;
			menu_prev_reg <= 1'b0;
		end else begin
			menu_prev_reg <= key_menu;
			if (do_write && write_hit && awaddr_reg == `FEED_CTRL_ADDR
				&& wmask[`CTRL_MENU_BIT] && wdata_reg[`CTRL_MENU_BIT]) begin
				at_main_reg <= 1'b1;
			end else if (ov_state != feed_pkg::OV_NONE && h_back.done) begin
				at_main_reg <= 1'b1;
			end else if (ov_state == feed_pkg::OV_NONE && key_menu
				&& !menu_prev_reg) begin
				at_main_reg <= 1'b0;
			end
		end
	end

	// ==================================================================
	// Feed outputs
	always_comb begin
		fwd_next = 1'b0;
		rev_next = 1'b0;
		show_next = feed_pkg::SHOW_IDLE;
		unique case (ov_state)
		feed_pkg::OV_NONE: begin
			fwd_next = auto_state != feed_pkg::AUTO_OFF
				&& (auto_state == feed_pkg::AUTO_FWD || hold_fwd);
			rev_next = auto_state == feed_pkg::AUTO_REV;
		end
		feed_pkg::OV_IDLE: begin
			show_next = feed_pkg::SHOW_IDLE;
		end
		feed_pkg::OV_FWD: begin
			fwd_next = 1'b1;
			show_next = feed_pkg::SHOW_FORWARD;
		end
		feed_pkg::OV_REV: begin
			fwd_next = hold_fwd;
			rev_next = 1'b1;
			show_next = feed_pkg::SHOW_REVERSE;
		end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			feed_forward <= 1'b0;
			feed_reverse <= 1'b0;
			feed_display <= 2'h0;
			override_active <= 1'b0;
		end else begin
			feed_forward <= fwd_next && manual && engine_running;
			feed_reverse <= rev_next && manual && engine_running;
			feed_display <= show_next;
			override_active <= ov_state != feed_pkg::OV_NONE;
		end
	end

	// ==================================================================
	// Interrupts
	always_comb begin
		irq_set = 4'h0;
		irq_set[`IRQ_WARN_BIT] = ov_state == feed_pkg::OV_NONE
			&& h_enter.done && engine_speed >= rev_trig_reg;
		irq_set[`IRQ_PULSE_BIT] = auto_run && auto_state == feed_pkg::AUTO_FWD
			&& engine_speed <= rev_trig_reg;
		irq_set[`IRQ_ENTER_BIT] = ov_state == feed_pkg::OV_NONE
			&& h_enter.done && engine_speed < rev_trig_reg;
		irq_set[`IRQ_EXIT_BIT] = ov_state != feed_pkg::OV_NONE && h_back.done;
		irq_clr = 4'h0;
		if (do_write && awaddr_reg == `FEED_IRQ_STATUS_ADDR) begin
			irq_clr = wdata_reg[3:0] & wmask[3:0];
		end
	end

	// A new event wins over a clear written in the same cycle.
	always_ff @(posedge clock) begin
		if (reset) begin
			irq_status_reg <= 4'h0;
			irq <= 1'b0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
			irq <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
		end
	end

	// ==================================================================
	// AXI4-Lite write channel
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign write_hit = awaddr_reg <= `FEED_IRQ_MASK_ADDR
		&& awaddr_reg[1:0] == 2'h0 && awaddr_reg != `FEED_STATUS_ADDR;

	always_ff @(posedge clock) begin
		if (reset) begin
			aw_have_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_reg <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_have_reg <= 1'b0;
		end else if (!aw_have_reg && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			w_have_reg <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_reg <= 1'b0;
		end else if (!w_have_reg && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= write_hit ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_reg <= `CTRL_RESET;
			feed_on_reg <= `FEED_ON_RESET;
			rev_trig_reg <= `FEED_REV_RESET;
			pulse_reg <= `FEED_PULSE_RESET;
			irq_mask_reg <= `IRQ_MASK_RESET;
		end else if (do_write) begin
			unique case (awaddr_reg)
			`FEED_CTRL_ADDR: ctrl_reg <= (ctrl_reg & ~wmask[2:0])
				| (wdata_reg[2:0] & wmask[2:0]);
			`FEED_ON_ADDR: feed_on_reg <= (feed_on_reg & ~wmask[15:0])
				| (wdata_reg[15:0] & wmask[15:0]);
			`FEED_REV_ADDR: rev_trig_reg <= (rev_trig_reg & ~wmask[15:0])
				| (wdata_reg[15:0] & wmask[15:0]);
			`FEED_PULSE_ADDR: pulse_reg <= (pulse_reg & ~wmask[15:0])
				| (wdata_reg[15:0] & wmask[15:0]);
			`FEED_IRQ_MASK_ADDR: irq_mask_reg <= (irq_mask_reg & ~wmask[3:0])
				| (wdata_reg[3:0] & wmask[3:0]);
			default: begin
			end
			endcase
		end
	end

	// ==================================================================
	// AXI4-Lite read channel
	always_comb begin
		read_data = 32'h0000_0000;
		read_hit = 1'b1;
		unique case (s_axi_araddr)
		`FEED_CTRL_ADDR: read_data = {28'h0000000, at_main_reg, ctrl_reg};
		`FEED_ON_ADDR: read_data = {16'h0000, feed_on_reg};
		`FEED_REV_ADDR: read_data = {16'h0000, rev_trig_reg};
		`FEED_PULSE_ADDR: read_data = {16'h0000, pulse_reg};
		`FEED_STATUS_ADDR: read_data = {10'h000, engine_speed,
			auto_state == feed_pkg::AUTO_REV, override_active,
			feed_display, feed_reverse, feed_forward};
		`FEED_IRQ_STATUS_ADDR: read_data = {28'h0000000, irq_status_reg};
		`FEED_IRQ_MASK_ADDR: read_data = {28'h0000000, irq_mask_reg};
		default: read_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_data;
			s_axi_rresp <= read_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==================================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	unstarted_feed_off_a: assert property (
		!engine_running |=> !feed_forward && !feed_reverse)
		else $error("feed active before engine start");
	manual_mode_only_a: assert property (
		!manual |=> ##1 !feed_forward && !feed_reverse && !override_active)
		else $error("feed active outside manual mode");
	engage_at_speed_a: assert property (
		auto_run && auto_state == feed_pkg::AUTO_OFF
		&& engine_speed >= feed_on_reg && manual && engine_running
		##1 auto_run |=> feed_forward)
		else $error("forward feed not engaged at feed-on speed");
	reverse_drop_a: assert property (
		auto_run && auto_state == feed_pkg::AUTO_FWD && !hold_fwd
		&& engine_speed <= rev_trig_reg ##1 auto_run && !hold_fwd
		|=> !feed_forward && feed_reverse)
		else $error("on-off-on reverse not started");
	dump_keeps_fwd_a: assert property (
		auto_run && auto_state == feed_pkg::AUTO_FWD && hold_fwd
		&& engine_speed <= rev_trig_reg ##1 auto_run && hold_fwd
		|=> feed_forward && feed_reverse)
		else $error("hold-forward reverse wrong");
	pulse_expiry_a: assert property (
		auto_run && auto_state == feed_pkg::AUTO_REV && pulse_expired
		|=> auto_state == feed_pkg::AUTO_OFF)
		else $error("reverse pulse did not end");
	overspeed_refused_a: assert property (
		manual && ov_state == feed_pkg::OV_NONE && h_enter.done
		&& engine_speed >= rev_trig_reg
		|=> ov_state == feed_pkg::OV_NONE && irq_status_reg[`IRQ_WARN_BIT])
		else $error("override entered above trigger speed");
	manual_forward_a: assert property (
		manual && ov_state != feed_pkg::OV_NONE && h_up.done && !h_enter.done
		&& !h_back.done |=> ov_state == feed_pkg::OV_FWD)
		else $error("forward hold not obeyed");
	manual_reverse_a: assert property (
		manual && ov_state == feed_pkg::OV_REV && engine_running
		##1 manual && engine_running && ov_state == feed_pkg::OV_REV
		|-> feed_reverse && feed_forward == $past(hold_fwd))
		else $error("manual reverse outputs wrong");
	feed_off_hold_a: assert property (
		manual && ov_state != feed_pkg::OV_NONE && h_enter.done
		&& !h_back.done |=> ov_state == feed_pkg::OV_IDLE
		##1 !feed_forward && !feed_reverse)
		else $error("feed off hold not obeyed");
	override_exit_a: assert property (
		manual && ov_state != feed_pkg::OV_NONE && h_back.done
		|=> ov_state == feed_pkg::OV_NONE && at_main_reg)
		else $error("back hold did not leave override");

	auto_cycle_c: cover property (auto_state == feed_pkg::AUTO_REV
		##[1:100] auto_state == feed_pkg::AUTO_OFF);
	manual_fwd_c: cover property (ov_state == feed_pkg::OV_FWD);
	refusal_c: cover property (irq_set[`IRQ_WARN_BIT]);
endmodule

// [include/chipper_feed_regs.svh]
`ifndef CHIPPER_FEED_REGS_SVH
`define CHIPPER_FEED_REGS_SVH

// ==================================================================
// Register offsets
`define FEED_CTRL_ADDR 8'h00
`define FEED_ON_ADDR 8'h04
`define FEED_REV_ADDR 8'h08
`define FEED_PULSE_ADDR 8'h0c
`define FEED_STATUS_ADDR 8'h10
`define FEED_IRQ_STATUS_ADDR 8'h14
`define FEED_IRQ_MASK_ADDR 8'h18

// ==================================================================
// Field positions
`define CTRL_MANUAL_BIT 0
`define CTRL_ENGINE_BIT 1
`define CTRL_VARIANT_BIT 2
`define CTRL_MENU_BIT 3
`define IRQ_WARN_BIT 0
`define IRQ_PULSE_BIT 1
`define IRQ_ENTER_BIT 2
`define IRQ_EXIT_BIT 3

// ==================================================================
// Reset values
`define CTRL_RESET 3'h0
`define FEED_ON_RESET 16'h0898
`define FEED_REV_RESET 16'h0708
`define FEED_PULSE_RESET 16'h0032
`define IRQ_MASK_RESET 4'h0

// ==================================================================
// Timing
`define CLOCK_PERIOD_NS 20
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`TICK_PERIOD_US * 1000) / `CLOCK_PERIOD_NS)
`define HOLD_TIME_MS 5000
`define HOLD_TICKS ((`HOLD_TIME_MS * 1000) / `TICK_PERIOD_US)
`endif

// [include/feed_pkg.sv]
package feed_pkg;
	typedef logic [15:0] speed_t;
	typedef enum {AUTO_OFF, AUTO_FWD, AUTO_REV} auto_state_e;
	typedef enum {OV_NONE, OV_IDLE, OV_FWD, OV_REV} override_state_e;
	typedef enum logic {VARIANT_ON_OFF_ON, VARIANT_HOLD_FORWARD} variant_e;
	typedef enum logic [1:0] {SHOW_IDLE, SHOW_FORWARD, SHOW_REVERSE} show_e;
endpackage

// [include/hold_if.sv]
`timescale 1ns/10ps
interface hold_if;
	logic active;
	logic done;
	modport timer (input active, output done);
	modport user (output active, input done);
endinterface

// [hw/tick_divider.sv]
`timescale 1ns/10ps
module tick_divider #(
	parameter int CYCLES = 50000
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// One-cycle enable.
	output logic tick
);
	logic [15:0] count_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			count_reg <= 16'h0000;
			tick <= 1'b0;
		end else if (count_reg == 16'(CYCLES - 1)) begin
			count_reg <= 16'h0000;
			tick <= 1'b1;
		end else begin
			count_reg <= count_reg + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

// [hw/key_hold_timer.sv]
`timescale 1ns/10ps
module key_hold_timer #(
	parameter int HOLD = 5000
) (
	// Clock, reset and time base.
	input wire logic clock,
	input wire logic reset,
	input wire logic tick,
	// Key condition in, hold reached out.
	hold_if.timer hold
);
	logic [12:0] count_reg;
	logic fired_reg;

	// A hold fires once; the keys must be let go before it can fire again.
	always_ff @(posedge clock) begin
		if (reset || !hold.active) begin
			count_reg <= 13'h0000;
			fired_reg <= 1'b0;
			hold.done <= 1'b0;
		end else if (tick && !fired_reg) begin
			if (count_reg == 13'(HOLD - 1)) begin
				fired_reg <= 1'b1;
				hold.done <= 1'b1;
			end else begin
				count_reg <= count_reg + 13'h0001;
			end
		end else begin
			hold.done <= 1'b0;
		end
	end

	done_needs_hold_a: assert property (@(posedge clock) disable iff (reset)
		hold.done |-> $past(hold.active) && $past(count_reg) == 13'(HOLD - 1))
		else $error("hold fired without a full hold");
endmodule

// [verif/speed_source.sv]
`timescale 1ns/10ps
// ==================================================================
// Engine speed pickup and feed valve model
module speed_source (
	// Clock.
	input wire logic clock,
	// Commanded engine speed and feed valve drives.
	input wire logic [15:0] speed_cmd,
	input wire logic feed_forward,
	input wire logic feed_reverse,
	// Sensed speed and length of the last reverse pulse in cycles.
	output logic [15:0] engine_speed,
	output logic [15:0] rev_len
);
	logic [15:0] run_len;
	// The pickup delivers one fresh sample per clock, like a real sensor.
	always_ff @(posedge clock) begin
		engine_speed <= speed_cmd;
	end
	// The valve times how long reverse stays energised.
	always_ff @(posedge clock) begin
		if (feed_reverse) begin
			run_len <= run_len + 16'h0001;
		end else begin
			if (run_len != 16'h0000) begin
				rev_len <= run_len;
			end
			run_len <= 16'h0000;
		end
	end
endmodule

// [verif/tb.sv]
`timescale 1ns/10ps
`include "chipper_feed_regs.svh"
module tb;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [4:0] keys = 5'h00;
	logic [15:0] speed_cmd = 16'h0000;
	logic [15:0] engine_speed, rev_len;
	logic feed_forward, feed_reverse, override_active, irq;
	logic [1:0] feed_display, s_axi_bresp, s_axi_rresp, resp;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [31:0] s_axi_rdata, rdat;
	logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18};
	logic [31:0] rv [5] = '{32'h0, 32'h898, 32'h708, 32'h32, 32'h0};
	int n_errors = 0;
	int check_count = 0;

	always #10 clock = ~clock;

	speed_source partner (.clock(clock), .speed_cmd(speed_cmd),
		.feed_forward(feed_forward), .feed_reverse(feed_reverse),
		.engine_speed(engine_speed), .rev_len(rev_len));

	chipper_feed_control #(.TICK_CYCLES(5), .HOLD_TICKS(4)) dut (
		.clock(clock), .reset(reset), .engine_speed(engine_speed),
		.key_enter(keys[0]), .key_up(keys[1]), .key_down(keys[2]),
		.key_back(keys[3]), .key_menu(keys[4]),
		.feed_forward(feed_forward), .feed_reverse(feed_reverse),
		.feed_display(feed_display), .override_active(override_active),
		.irq(irq), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	// ==================================================================
	// Reporting
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic timeout();
		n_errors++;
		$display("[FAIL] %0t wait ran out", $time);
		finish_test();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ==================================================================
	// Register bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		if (n >= 50) timeout();
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		if (n >= 50) timeout();
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// ==================================================================
	// Feed and keypad helpers
	// Reverse leaves forward on only in the hold-forward variant.
	function automatic logic [1:0] rev_outputs(input logic hold);
		return {hold, 1'b1};
	endfunction

	task automatic spd(input logic [15:0] v);
		@(posedge clock);
		speed_cmd <= v;
	endtask

	task automatic wait_out(input logic [1:0] exp, input int lim);
		int n;
		n = 0;
		while ({feed_forward, feed_reverse} !== exp && n < lim) begin
			@(posedge clock);
			n++;
		end
		check({feed_forward, feed_reverse}, exp);
	endtask

	// The arrow goes down two cycles before enter joins it.
	task automatic press(input logic [4:0] first, all, input int len);
		@(posedge clock);
		keys <= first;
		repeat (2) @(posedge clock);
		keys <= all;
		repeat (len) @(posedge clock);
		keys <= 5'h00;
		repeat (4) @(posedge clock);
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		timeout();
	end

	initial begin
		void'($urandom(32'h205e));
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i]);
			check(rdat, rv[i]);
		end
		rd(8'h1c);
		check(rdat, 32'h0);
		check(resp, 2'b10);
		wr(8'h1c, 32'h0);
		check(resp, 2'b10);
		wr(`FEED_STATUS_ADDR, 32'h0);
		check(resp, 2'b10);
		wr(`FEED_IRQ_MASK_ADDR, 32'hf);
		wr(`FEED_PULSE_ADDR, 32'h3);
		for (int v = 0; v < 2; v++) begin
			wr(`FEED_IRQ_STATUS_ADDR, 32'hf);
			wr(`FEED_CTRL_ADDR, {v[0], 2'b11});
			spd(16'd2199);
			repeat (6) @(posedge clock);
			wait_out(2'b00, 0);
			spd(16'd2200);
			wait_out(2'b10, 10);
			spd(16'd1801);
			repeat (6) @(posedge clock);
			wait_out(2'b10, 0);
			spd(16'd1800);
			wait_out(rev_outputs(v[0]), 10);
			spd(16'd1801 + 16'($urandom % 398));
			wait_out(2'b00, 40);
			repeat (6) @(posedge clock);
			check(rev_len >= 10 && rev_len <= 15, 1);
			wait_out(2'b00, 0);
			check(irq, 1'b1);
			wr(`FEED_IRQ_STATUS_ADDR, 32'hf);
			repeat (2) @(posedge clock);
			check(irq, 1'b0);
			spd(16'd2200 + 16'($urandom % 800));
			wait_out(2'b10, 10);
			wr(`FEED_CTRL_ADDR, {v[0], 2'b01});
			wait_out(2'b00, 10);
			wr(`FEED_CTRL_ADDR, {v[0], 2'b11});
			wait_out(2'b10, 10);
			wr(`FEED_CTRL_ADDR, {v[0], 2'b10});
			wait_out(2'b00, 10);
			spd(16'd1800);
			wr(`FEED_CTRL_ADDR, {v[0], 2'b11});
			repeat (40) @(posedge clock);
			wr(`FEED_IRQ_STATUS_ADDR, 32'hf);
			wr(`FEED_CTRL_ADDR, {1'b1, v[0], 2'b11});
			press(5'h01, 5'h01, 32);
			check(override_active, 1'b0);
			check(irq, 1'b1);
			rd(`FEED_IRQ_STATUS_ADDR);
			check(rdat[0], 1'b1);
			wr(`FEED_IRQ_STATUS_ADDR, 32'hf);
			repeat (2) @(posedge clock);
			check(irq, 1'b0);
			spd(16'($urandom % 1800));
			press(5'h01, 5'h01, 8);
			press(5'h01, 5'h01, 8);
			check(override_active, 1'b0);
			press(5'h01, 5'h01, 32);
			check({override_active, feed_display}, 3'b100);
			wait_out(2'b00, 0);
			press(5'h02, 5'h03, 32);
			wait_out(2'b10, 0);
			check(feed_display, 2'h1);
			press(5'h04, 5'h05, 32);
			wait_out(rev_outputs(v[0]), 0);
			check(feed_display, 2'h2);
			press(5'h01, 5'h01, 32);
			wait_out(2'b00, 0);
			check(feed_display, 2'h0);
			press(5'h08, 5'h08, 32);
			check(override_active, 1'b0);
			press(5'h10, 5'h10, 8);
			rd(`FEED_CTRL_ADDR);
			check(rdat[3], 1'b0);
		end
		finish_test();
	end
endmodule
